// [verilog/nps_pkg.sv]
package nps_pkg;

  // ***************************************************
  // time base and timing constants
  // ***************************************************
  localparam int CLK_MHZ        = 50;                 // ref_clk rate
  localparam int CLK_NS         = 20;                 // ref_clk period
  localparam int WIDTH_MIN_NS   = 20;                 // shortest pulse, 0.02 us
  localparam int WIDTH_MAX_NS   = 20020;              // longest pulse, 20.02 us
  localparam int WIDTH_MIN_CYC  = (WIDTH_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int WIDTH_MAX_CYC  = WIDTH_MAX_NS / CLK_NS;
  localparam int SYNC_NS        = 1000;               // scope trigger, about 1 us
  localparam int SYNC_CYC       = SYNC_NS / CLK_NS;
  localparam int BLANK_TAIL_NS  = 200;                // blanking overhang after a pulse
  localparam int BLANK_TAIL_CYC = BLANK_TAIL_NS / CLK_NS;
  localparam int DELAY_MIN_US   = 100;                // 0.0001 s
  localparam int DELAY_MAX_US   = 9999000;            // 9.999 s
  localparam int PERIOD_MIN_US  = 200;                // 0.2 ms
  localparam int PERIOD_MAX_US  = 100000000;          // 100 s
  localparam int MAX_SECOND     = 100;                // most second pulses

  // ***************************************************
  // field widths
  // ***************************************************
  localparam int WW = 10;                             // width counter bits
  localparam int TW = 33;                             // long time counter bits
  localparam int NW = 7;                              // pulse count bits

  // settings from the front panel
  typedef struct packed {
    logic [WW-1:0] first_width;     // cycles
    logic [WW-1:0] second_width;    // cycles
    logic [TW-1:0] delay;           // cycles, first to first second pulse
    logic [TW-1:0] period;          // cycles, internal repetition
    logic [NW-1:0] second_count;    // 0..100
    logic          manual_period;   // period set to manual
    logic          sync_on_second;  // trigger on second pulses
    logic          first_enable;
    logic          second_enable;
    logic          quadrature_shift_disable;
  } nps_cfg_t;

  // outputs towards synthesizer, receiver and scope
  typedef struct packed {
    logic gate_i;
    logic gate_q;
    logic blank;
    logic sync;
  } nps_out_t;

endpackage : nps_pkg

// [verilog/nps_timer.sv]
// Contract
// - exactly one first pulse per sequence
// - zero to 100 second pulses follow
// - both widths programmable 0.02 to 20.02 us
// - first-to-second delay 0.0001 to 9.999 s
// - internal mode repeats every programmed period
// - manual period: one sequence per button press
// - about 1 us sync on chosen pulse
// - enables mask gate outputs only, timing unchanged
// - second pulses on quadrature unless disabled
// - blanking covers pulse plus short overhang
// - external TTL start runs one sequence
// - pulses gate separate in-phase and quadrature outputs
`timescale 1ns/1ps

module nps_timer (
  // clock and reset
  input  wire logic            ref_clk,
  input  wire logic            rst,
  // settings, static levels from the panel
  input  wire nps_pkg::nps_cfg_t cfg,
  // start sources, asynchronous pins
  input  wire logic            manual_start,
  input  wire logic            ext_start,
  // pulse outputs
  output nps_pkg::nps_out_t    pulses,
  output logic                 busy
);

  // ***************************************************
  // start synchronisers and edge detection
  // ***************************************************
  logic [1:0] man_sync, ext_sync;
  logic       man_prev, ext_prev;
  logic [1:0] next_man_sync, next_ext_sync;
  logic       next_man_prev, next_ext_prev;
  logic       man_edge, ext_edge;

  // only the second stage feeds the edge detector
  always_comb begin
    next_man_sync = {man_sync[0], manual_start};
    next_ext_sync = {ext_sync[0], ext_start};
    next_man_prev = man_sync[1];
    next_ext_prev = ext_sync[1];
    man_edge      = man_sync[1] & ~man_prev;
    ext_edge      = ext_sync[1] & ~ext_prev;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      man_sync <= 2'h0;
      ext_sync <= 2'h0;
      man_prev <= 1'b0;
      ext_prev <= 1'b0;
    end else begin
      man_sync <= next_man_sync;
      ext_sync <= next_ext_sync;
      man_prev <= next_man_prev;
      ext_prev <= next_ext_prev;
    end
  end

  // ***************************************************
  // repetition period counter
  // ***************************************************
  logic [nps_pkg::TW-1:0] per_cnt, next_per_cnt;
  logic                   per_tick;

  always_comb begin
    per_tick     = 1'b0;
    next_per_cnt = per_cnt + nps_pkg::TW'(1);
    if (cfg.manual_period) begin
      next_per_cnt = '0;
    end else if (per_cnt + nps_pkg::TW'(1) >= cfg.period) begin
      per_tick     = 1'b1;
      next_per_cnt = '0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) per_cnt <= '0;
    else     per_cnt <= next_per_cnt;
  end

  // manual press starts one run; ext pulse starts one run
  logic start_req;
  assign start_req = per_tick | man_edge | ext_edge;

  // ***************************************************
  // sequence state machine
  // ***************************************************
  typedef enum logic [3:0] {
    NPS_IDLE   = 4'h1,
    NPS_FIRST  = 4'h2,
    NPS_WAIT   = 4'h4,
    NPS_SECOND = 4'h8
  } nps_state_t;

  nps_state_t             state, next_state;
  logic [nps_pkg::TW-1:0] tcnt, next_tcnt;
  logic [nps_pkg::NW-1:0] left, next_left;
  logic                   first_gap, next_first_gap;
  logic                   pulse_done, wait_done;
  logic [nps_pkg::NW-1:0] count_clip;

  // count clipped at the documented maximum
  assign count_clip = (cfg.second_count > nps_pkg::NW'(nps_pkg::MAX_SECOND))
                    ? nps_pkg::NW'(nps_pkg::MAX_SECOND) : cfg.second_count;
  assign pulse_done = (state == NPS_FIRST)
                    ? (tcnt[nps_pkg::WW-1:0] + nps_pkg::WW'(1) >= cfg.first_width)
                    : (tcnt[nps_pkg::WW-1:0] + nps_pkg::WW'(1) >= cfg.second_width);
  // first gap is tau; later gaps are twice tau
  assign wait_done  = first_gap ? (tcnt + nps_pkg::TW'(1) >= cfg.delay)
                                : (tcnt + nps_pkg::TW'(1) >= {cfg.delay[nps_pkg::TW-2:0], 1'b0});

  always_comb begin
    next_state     = state;
    next_tcnt      = tcnt + nps_pkg::TW'(1);
    next_left      = left;
    next_first_gap = first_gap;
    unique case (state)
      NPS_IDLE: begin
        next_tcnt = '0;
        // a start launches exactly one first pulse; starts mid-run ignored
        if (start_req) begin
          next_state     = NPS_FIRST;
          next_left      = count_clip;
          next_first_gap = 1'b1;
        end
      end
      NPS_FIRST, NPS_SECOND: begin
        if (pulse_done) begin
          next_tcnt = '0;
          if (left == '0) begin
            next_state = NPS_IDLE;
          end else begin
            next_state = NPS_WAIT;
          end
        end
      end
      NPS_WAIT: begin
        if (wait_done) begin
          next_tcnt      = '0;
          next_state     = NPS_SECOND;
          next_left      = left - nps_pkg::NW'(1);
          next_first_gap = 1'b0;
        end
      end
      default: begin
        next_state = NPS_IDLE;
        next_tcnt  = '0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state     <= NPS_IDLE;
      tcnt      <= '0;
      left      <= '0;
      first_gap <= 1'b0;
    end else begin
      state     <= next_state;
      tcnt      <= next_tcnt;
      left      <= next_left;
      first_gap <= next_first_gap;
    end
  end

  // ***************************************************
  // output shaping: gates, blanking, sync
  // ***************************************************
  logic                   in_first, in_second, pulse_start;
  logic [7:0]             blank_cnt, next_blank_cnt;
  logic [7:0]             sync_cnt, next_sync_cnt;
  nps_pkg::nps_out_t      next_pulses;
  logic                   next_busy;

  assign in_first    = (next_state == NPS_FIRST);
  assign in_second   = (next_state == NPS_SECOND);
  assign pulse_start = (in_first & state != NPS_FIRST) | (in_second & state != NPS_SECOND);

  always_comb begin
    next_pulses = '0;
    // enables gate outputs only; quadrature unless disabled
    // separate I and Q gate outputs
    next_pulses.gate_i = (in_first & cfg.first_enable)
                       | (in_second & cfg.second_enable & cfg.quadrature_shift_disable);
    next_pulses.gate_q = in_second & cfg.second_enable & ~cfg.quadrature_shift_disable;
    // blank during pulse, then short overhang
    next_blank_cnt = (blank_cnt != '0) ? blank_cnt - 8'h01 : 8'h00;
    if (in_first | in_second) next_blank_cnt = 8'(nps_pkg::BLANK_TAIL_CYC);
    next_pulses.blank = in_first | in_second | (blank_cnt != '0);
    // sync on first or second pulse start
    next_sync_cnt = (sync_cnt != '0) ? sync_cnt - 8'h01 : 8'h00;
    if (pulse_start & (in_second == cfg.sync_on_second)) next_sync_cnt = 8'(nps_pkg::SYNC_CYC);
    next_pulses.sync = (next_sync_cnt != '0);
    next_busy = (next_state != NPS_IDLE);
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pulses    <= '0;
      busy      <= 1'b0;
      blank_cnt <= 8'h00;
      sync_cnt  <= 8'h00;
    end else begin
      pulses    <= next_pulses;
      busy      <= next_busy;
      blank_cnt <= next_blank_cnt;
      sync_cnt  <= next_sync_cnt;
    end
  end

  // ***************************************************
  // checks
  // ***************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // second pulse that belongs on the quadrature gate
  logic q_due;
  assign q_due = (state == NPS_SECOND) & cfg.second_enable & ~cfg.quadrature_shift_disable;

  // falling end of either rf gate
  sequence s_gate_end;
    $fell(pulses.gate_i || pulses.gate_q);
  endsequence

  // a running sequence never launches another first pulse
  a_first_once: assert property ((state == NPS_WAIT || state == NPS_SECOND) |=> state != NPS_FIRST)
    else $error("second first pulse in run");
  a_count_cap: assert property (left <= nps_pkg::NW'(nps_pkg::MAX_SECOND))
    else $error("second pulse count above maximum");
  // first pulse neither ends early nor overruns its width
  a_width_min: assert property (state == NPS_FIRST && int'(tcnt) + 1 < int'(cfg.first_width)
    |=> state == NPS_FIRST) else $error("first pulse ended early");
  a_width_end: assert property (state == NPS_FIRST && int'(tcnt) + 1 >= int'(cfg.first_width)
    |=> state != NPS_FIRST) else $error("first pulse overran its width");
  a_gate_masked: assert property (!cfg.first_enable && state == NPS_FIRST |-> !pulses.gate_i)
    else $error("disabled first pulse reached output");
  a_q_shift: assert property (q_due |-> pulses.gate_q && !pulses.gate_i)
    else $error("second pulse not on quadrature");
  a_blank_cover: assert property ((pulses.gate_i || pulses.gate_q) |-> pulses.blank)
    else $error("gate without blanking");
  // blanking outlasts the gate so the receiver recovers unseen
  a_blank_tail: assert property (s_gate_end |-> pulses.blank[*8])
    else $error("blanking ends with pulse");
  a_ext_start: assert property ($rose(ext_sync[1]) && state == NPS_IDLE |=> state == NPS_FIRST)
    else $error("external start ignored");
  a_sync_len: assert property ($rose(pulses.sync) |-> pulses.sync[*8])
    else $error("sync pulse too short");

endmodule : nps_timer

// [tb/nps_far_end.sv]
`timescale 1ns/1ps

// ************************************************
// far side: synthesizer gate inputs and receiver blanking input
// ************************************************
module nps_far_end (
  // clock
  input  wire logic              ref_clk,
  // lines from the timer
  input  wire nps_pkg::nps_out_t pulses,
  // tallies for the bench
  output int                     i_cnt,
  output int                     q_cnt,
  output int                     sync_cnt,
  output int                     i_len,
  output int                     q_len,
  output int                     bad_blank,
  output int                     last_gap,
  output int                     prev_gap,
  output int                     b_len,
  output int                     s_len
);
  logic prev_i   = 1'b0;
  logic prev_q   = 1'b0;
  logic prev_s   = 1'b0;
  logic prev_b   = 1'b0;
  logic prev_any = 1'b0;
  int   i_run    = 0;
  int   q_run    = 0;
  int   b_run    = 0;
  int   s_run    = 0;
  int   gap_run  = 0;

  // clear the tallies before the first edge
  initial begin
    i_cnt = 0;
    q_cnt = 0;
    sync_cnt = 0;
    i_len = 0;
    q_len = 0;
    bad_blank = 0;
    last_gap = 0;
    prev_gap = 0;
    b_len = 0;
    s_len = 0;
  end

  // count bursts per channel; lengths kept from the last finished burst only
  always @(posedge ref_clk) begin
    if (pulses.gate_i && !prev_i) i_cnt++;
    if (pulses.gate_q && !prev_q) q_cnt++;
    if (pulses.sync && !prev_s) sync_cnt++;
    if (!pulses.gate_i && prev_i) i_len = i_run;
    if (!pulses.gate_q && prev_q) q_len = q_run;
    i_run = pulses.gate_i ? i_run + 1 : 0;
    q_run = pulses.gate_q ? q_run + 1 : 0;
    if ((pulses.gate_i || pulses.gate_q) && !pulses.blank) bad_blank++;
    if ((pulses.gate_i || pulses.gate_q) && !prev_any) begin
      prev_gap = last_gap;
      last_gap = gap_run;
    end
    gap_run = (pulses.gate_i || pulses.gate_q) ? 0 : gap_run + 1;
    // blanking and sync lengths of the last finished pulse
    if (!pulses.blank && prev_b) b_len = b_run;
    if (!pulses.sync && prev_s) s_len = s_run;
    b_run = pulses.blank ? b_run + 1 : 0;
    s_run = pulses.sync ? s_run + 1 : 0;
    prev_any = pulses.gate_i || pulses.gate_q;
    prev_b = pulses.blank;
    prev_i = pulses.gate_i;
    prev_q = pulses.gate_q;
    prev_s = pulses.sync;
  end
endmodule : nps_far_end

// [tb/tb_nps_timer.sv]
`timescale 1ns/1ps

// ************************************************
// bench for the pulse sequence timer
// ************************************************
module tb_nps_timer;
  logic              ref_clk      = 1'b0;
  logic              rst          = 1'b1;
  logic              manual_start = 1'b0;
  logic              ext_start    = 1'b0;
  logic              busy;
  nps_pkg::nps_cfg_t cfg;
  nps_pkg::nps_out_t pulses;
  int                i_cnt, q_cnt, sync_cnt, i_len, q_len, bad_blank;
  int                last_gap, prev_gap, b_len, s_len;
  int                err_count = 0;
  int                checks_done = 0;
  int                cycles = 0;
  int                base_busy, n, i0, q0, s0;

  // 50 MHz clock
  always #10 ref_clk = ~ref_clk;

  nps_timer u_nps_timer (.ref_clk(ref_clk), .rst(rst), .cfg(cfg), .manual_start(manual_start),
                         .ext_start(ext_start), .pulses(pulses), .busy(busy));
  nps_far_end u_nps_far_end (.ref_clk(ref_clk), .pulses(pulses), .i_cnt(i_cnt), .q_cnt(q_cnt),
                             .sync_cnt(sync_cnt), .i_len(i_len), .q_len(q_len), .bad_blank(bad_blank),
                             .last_gap(last_gap), .prev_gap(prev_gap), .b_len(b_len), .s_len(s_len));

  task check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task close_out;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out

  // hang guard, well above the whole run
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 40000) begin
      err_count++;
      close_out();
    end
  end

  task snap;
    i0 = i_cnt;
    q0 = q_cnt;
    s0 = sync_cnt;
  endtask : snap

  // one start pin held 1 us like a ttl source, then wait for the run to end
  task run_one(input logic use_ext, output int len);
    int k;
    len = 0;
    @(posedge ref_clk);
    #1;
    if (use_ext) ext_start = 1'b1;
    else manual_start = 1'b1;
    for (k = 0; k < 20000 && (k < 50 || len == 0 || busy === 1'b1); k++) begin
      @(posedge ref_clk);
      #1;
      if (k == 49) begin
        ext_start = 1'b0;
        manual_start = 1'b0;
      end
      if (busy === 1'b1) len++;
    end
    // a run that never ends is a failure, not a silent pass
    if (busy !== 1'b0) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, busy, 1'b0);
    end
  endtask : run_one

  task t_ext;
    snap();
    run_one(1'b1, base_busy);
    check(i_cnt - i0, 1);
    check(q_cnt - q0, 3);
    check(i_len, 3);
    check(q_len, 5);
    check(sync_cnt - s0, 1);
    check(s_len, nps_pkg::SYNC_CYC);
    check(bad_blank, 0);
    check(b_len, 5 + nps_pkg::BLANK_TAIL_CYC);
    check(base_busy, 3 + 40 + 3 * 5 + 2 * 2 * 40);
    $display("test external start done");
  endtask : t_ext

  task t_shift_off;
    cfg.quadrature_shift_disable = 1'b1;
    snap();
    run_one(1'b1, n);
    check(i_cnt - i0, 4);
    check(q_cnt - q0, 0);
    cfg.quadrature_shift_disable = 1'b0;
    $display("test shift disable done");
  endtask : t_shift_off

  task t_enables;
    cfg.first_enable = 1'b0;
    cfg.second_enable = 1'b0;
    snap();
    run_one(1'b1, n);
    check(i_cnt - i0, 0);
    check(q_cnt - q0, 0);
    check(n, base_busy);
    check(sync_cnt - s0, 1);
    cfg.first_enable = 1'b1;
    cfg.second_enable = 1'b1;
    $display("test enables done");
  endtask : t_enables

  task t_sync2;
    cfg.sync_on_second = 1'b1;
    cfg.second_count = 7'h02;
    snap();
    run_one(1'b1, n);
    check(sync_cnt - s0, 2);
    check(q_cnt - q0, 2);
    check(prev_gap, 40);
    check(last_gap, 2 * 40);
    cfg.sync_on_second = 1'b0;
    cfg.second_count = 7'h03;
    $display("test sync on second done");
  endtask : t_sync2

  // zero second pulses, then a count above the maximum
  task t_count_edges;
    cfg.second_count = 7'h00;
    snap();
    run_one(1'b1, n);
    check(i_cnt - i0, 1);
    check(q_cnt - q0, 0);
    check(n, 3);
    cfg.second_count = 7'h7F;
    snap();
    run_one(1'b1, n);
    check(q_cnt - q0, nps_pkg::MAX_SECOND);
    cfg.second_count = 7'h03;
    $display("test count limits done");
  endtask : t_count_edges

  task t_manual;
    snap();
    run_one(1'b0, n);
    check(i_cnt - i0, 1);
    snap();
    repeat (1500) @(posedge ref_clk);
    #1;
    check(i_cnt - i0, 0);
    $display("test manual start done");
  endtask : t_manual

  // free running period: 2000 cycles at 600 per period holds exactly three runs
  task t_internal;
    cfg.manual_period = 1'b0;
    snap();
    repeat (2000) @(posedge ref_clk);
    #1;
    check(i_cnt - i0, 3);
    $display("test internal period done");
  endtask : t_internal

  initial begin
    cfg = '0;
    cfg.first_width = 10'h003;
    cfg.second_width = 10'h005;
    cfg.delay = 33'h028;
    cfg.period = 33'h258;
    cfg.second_count = 7'h03;
    cfg.manual_period = 1'b1;
    cfg.first_enable = 1'b1;
    cfg.second_enable = 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    t_ext();
    t_shift_off();
    t_enables();
    t_sync2();
    t_count_edges();
    t_manual();
    t_internal();
    close_out();
  end
endmodule : tb_nps_timer
